// ==== pid_consts.svh ====
// Constants of the pin interrupt detector: register indices, reset values, field positions.
// Assumes inclusion by bare name from the detector sources.
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH

`define PID_IDX_MODE 8'h9a
`define PID_IDX_POLARITY 8'h9b
`define PID_IDX_ENABLE 8'h9c
`define PID_IDX_FLAGS 8'h9d
`define PID_IDX_EXT_CTRL 8'ha0

`define PID_RST_BYTE 8'h00
`define PID_RST_TRIG 2'h0
`define PID_RST_PIN_IDLE 2'h3

`define PID_EXT_TRIG_LSB 0
`define PID_EXT_FLAG_LSB 2

`define PID_MIN_HOLD_CYCLES 2

`endif

// ==== pid_det_if.sv ====
// Carrier between the register block and the port pin detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pid_det_if;
	logic [7:0] mode;
	logic [7:0] polarity;
	logic [7:0] enable;
	logic [7:0] hit;

	modport ctrl (output mode, output polarity, output enable, input hit);
	modport det (input mode, input polarity, input enable, output hit);
endinterface // pid_det_if

// ==== pid_pkg.sv ====
// Types shared by the pin interrupt detector modules.
// Assumes pid_consts.svh for the numeric constants.
package pid_pkg;

	typedef enum logic [2:0] {
		PID_SEL_NONE = 3'b000,
		PID_SEL_MODE = 3'b001,
		PID_SEL_POLARITY = 3'b010,
		PID_SEL_ENABLE = 3'b011,
		PID_SEL_FLAGS = 3'b100,
		PID_SEL_EXT_CTRL = 3'b101
	} pid_sel_t;

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [1:0] primed;
		logic [7:0] hit;
	} pid_port_state_t;

	typedef struct packed {
		logic [1:0] ext_sync1;
		logic [1:0] ext_sync2;
		logic [1:0] ext_prev;
		logic ext_primed;
		logic [1:0] trig_type;
		logic [1:0] ext_flag;
		logic [7:0] mode;
		logic [7:0] polarity;
		logic [7:0] enable;
		logic [7:0] flags;
		logic port_irq;
		logic wake_req;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pid_top_state_t;

endpackage

// ==== pid_port_detect.sv ====
// Port 1 pin interrupt detector: synchronises eight pins and reports enabled conditions.
// Assumes raw asynchronous pins and configuration from the register block on pclk.
`timescale 1ns/1ps
module pid_port_detect
	import pid_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] port1_pin_n,
	pid_det_if.det det
);

	pid_port_state_t st;
	pid_port_state_t next_st;
	logic [7:0] cond;

	always_comb begin
		next_st = st;
		next_st.sync1 = port1_pin_n;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		// The previous sample is trusted after one real sample, while it still holds its reset zero, so a high pin can look like a rising edge.
		next_st.primed = {st.primed[0], 1'b1};
		for (int i = 0; i < WIDTH; i++) begin
			if (det.mode[i]) begin
				cond[i] = det.polarity[i] ? (st.sync2[i] & ~st.prev[i]) : (~st.sync2[i] & st.prev[i]);
			end else begin
				cond[i] = det.polarity[i] ? (st.sync2[i] & st.prev[i]) : (~st.sync2[i] & ~st.prev[i]);
			end
		end
		next_st.hit = st.primed[1] ? (cond & det.enable) : 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign det.hit = st.hit;

endmodule // pid_port_detect

// ==== pid_props.sv ====
// Checker for the pin interrupt detector top ports.
// Assumes a bind onto pid_top, everything on pclk.
`timescale 1ns/1ps
module pid_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_request_pin_zero,
	input wire logic ext_request_pin_one,
	input wire logic power_down,
	input wire logic ext_request_flag_zero,
	input wire logic ext_request_flag_one,
	input wire logic port_irq,
	input wire logic wake_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	AST_PREADY_NEXT: assert property (s_setup |=> s_access) else $error("no answer after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
	AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_IRQ_STICKY: assert property (port_irq && !(psel && penable && pwrite) |=> port_irq)
		else $error("port request dropped");
	AST_WAKE_CAUSE: assert property ($rose(wake_req) |-> $past(power_down)) else $error("wake while awake");
	AST_WAKE_AWAKE: assert property (!power_down |=> !wake_req) else $error("wake without power down");
	AST_EXT0_CAUSE: assert property ($rose(ext_request_flag_zero) |-> !$past(ext_request_pin_zero, 2))
		else $error("request zero without low pin");
	AST_EXT1_CAUSE: assert property ($rose(ext_request_flag_one) |-> !$past(ext_request_pin_one, 2))
		else $error("request one without low pin");
endmodule // pid_props

// ==== pid_src.sv ====
// Model of the external sources on the request pins and port 1.
// Assumes its tasks are called from pclk-aligned code.
`timescale 1ns/1ps
module pid_src (
	input wire logic pclk,
	output logic ext_pin_zero,
	output logic ext_pin_one,
	output logic [7:0] port_pins
);
	initial begin
		ext_pin_zero = 1'b1;
		ext_pin_one = 1'b1;
		port_pins = 8'h00;
	end
	task automatic fall(input logic n);
		repeat (2) @(posedge pclk);
		if (n) ext_pin_one <= 1'b0;
		else ext_pin_zero <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic release_req;
		@(posedge pclk);
		ext_pin_zero <= 1'b1;
		ext_pin_one <= 1'b1;
	endtask
	task automatic drive(input logic [7:0] v);
		@(posedge pclk);
		port_pins <= v;
	endtask
endmodule // pid_src

// ==== pid_top.sv ====
// Pin interrupt detector: two dedicated request pins and eight port 1 pin interrupts behind APB.
// Assumes an APB master on pclk, asynchronous pins, and service acknowledge pulses from the CPU.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "pid_consts.svh"

// Notes on behaviour
// - Trigger type 0: a sampled low on the request pin is the request.
// - Trigger type 1: high sample then low sample sets the request flag.
// - Each dedicated pin is sampled once per clock; one low sample is enough for a level request.
// - Edge-mode request flag clears when the CPU enters the service routine.
// - Enabled port pin interrupts or either request pin wake from power-down.
// - Eight port 1 pins, each detecting high, low, rising or falling.
// - Mode bit 0 selects level detection, 1 selects edge detection.
// - Polarity bit 0 selects low or falling, 1 high or rising.
// - Port pins sampled every clock; level needs two successive samples.
// - Edge mode detects a change between samples in the chosen direction.
// - A flag bit sets for a detected condition on an enabled pin or for a software write of 1.
// - Enable bit 0 disables, 1 enables the matching pin interrupt.
// - Port flags stay set until software clears them; hardware never does.
module pid_top
	import pid_pkg::*;
#(
	parameter int ADDR_WIDTH = 12,
	parameter int PORT_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_request_pin_zero,
	input wire logic ext_request_pin_one,
	input wire logic [PORT_WIDTH-1:0] port1_pin_n,
	input wire logic svc_ack_zero,
	input wire logic svc_ack_one,
	input wire logic power_down,
	output logic ext_request_flag_zero,
	output logic ext_request_flag_one,
	output logic port_irq,
	output logic wake_req
);

	pid_top_state_t st;
	pid_top_state_t next_st;
	pid_det_if det_bus ();

	logic [1:0] svc_ack;
	logic setup_phase;
	logic access_done;
	logic wr_done;
	pid_sel_t rd_sel;
	pid_sel_t wr_sel;
	logic [7:0] wr_byte;
	logic [7:0] next_flags;

	// Index of a register to its word address; printed offsets are not word aligned.
	function automatic logic [ADDR_WIDTH-1:0] pid_word_addr(input logic [7:0] idx);
		pid_word_addr = ADDR_WIDTH'({idx, 2'b00});
	endfunction

	// Shared decode for the read and write paths; unmapped addresses give PID_SEL_NONE.
	function automatic pid_sel_t pid_decode(input logic [ADDR_WIDTH-1:0] addr);
		if (addr == pid_word_addr(`PID_IDX_MODE)) begin
			pid_decode = PID_SEL_MODE;
		end else if (addr == pid_word_addr(`PID_IDX_POLARITY)) begin
			pid_decode = PID_SEL_POLARITY;
		end else if (addr == pid_word_addr(`PID_IDX_ENABLE)) begin
			pid_decode = PID_SEL_ENABLE;
		end else if (addr == pid_word_addr(`PID_IDX_FLAGS)) begin
			pid_decode = PID_SEL_FLAGS;
		end else if (addr == pid_word_addr(`PID_IDX_EXT_CTRL)) begin
			pid_decode = PID_SEL_EXT_CTRL;
		end else begin
			pid_decode = PID_SEL_NONE;
		end
	endfunction

	pid_port_detect #(
		.WIDTH(PORT_WIDTH)
	) u_port_detect (
		.pclk(pclk),
		.presetn(presetn),
		.port1_pin_n(port1_pin_n),
		.det(det_bus.det)
	);

	assign det_bus.mode = st.mode;
	assign det_bus.polarity = st.polarity;
	assign det_bus.enable = st.enable;

	assign svc_ack = {svc_ack_one, svc_ack_zero};
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & st.pready;
	assign wr_done = access_done & pwrite & ~st.pslverr;
	assign rd_sel = pid_decode(paddr);
	assign wr_sel = pid_decode(paddr);
	// Only the low byte lane carries register data; a write without it changes nothing.
	assign wr_byte = pwdata[7:0];

	always_comb begin
		next_st = st;

		next_st.ext_sync1 = {ext_request_pin_one, ext_request_pin_zero};
		next_st.ext_sync2 = st.ext_sync1;
		next_st.ext_prev = st.ext_sync2;
		next_st.ext_primed = 1'b1;

		for (int i = 0; i < 2; i++) begin
			if (st.trig_type[i]) begin
				if (st.ext_primed && st.ext_prev[i] && !st.ext_sync2[i]) begin
					next_st.ext_flag[i] = 1'b1;
				end else if (svc_ack[i]) begin
					next_st.ext_flag[i] = 1'b0;
				end
			end else begin
				next_st.ext_flag[i] = ~st.ext_sync2[i];
			end
		end

		if (wr_done && pstrb[0]) begin
			case (wr_sel)
				PID_SEL_MODE: begin
					next_st.mode = wr_byte;
				end
				PID_SEL_POLARITY: begin
					next_st.polarity = wr_byte;
				end
				PID_SEL_ENABLE: begin
					next_st.enable = wr_byte;
				end
				PID_SEL_EXT_CTRL: begin
					next_st.trig_type = wr_byte[`PID_EXT_TRIG_LSB +: 2];
					// A change of a pin's trigger type drops that pin's pending request, edge or level.
					if (wr_byte[`PID_EXT_TRIG_LSB +: 2] != st.trig_type) begin
						next_st.ext_flag = next_st.ext_flag & ~(st.trig_type ^ wr_byte[`PID_EXT_TRIG_LSB +: 2]);
					end
				end
				default: begin
				end
			endcase
		end

		next_flags = st.flags;
		if (wr_done && pstrb[0] && wr_sel == PID_SEL_FLAGS) begin
			next_flags = wr_byte;
		end
		next_st.flags = next_flags | det_bus.hit;

		next_st.port_irq = |next_st.flags;

		next_st.wake_req = power_down & ((|next_st.flags) | (|next_st.ext_flag));

		// Registered answer: read data are captured in the setup cycle, so there is no wait state.
		next_st.pready = setup_phase;
		if (setup_phase) begin
			next_st.pslverr = (rd_sel == PID_SEL_NONE);
			case (rd_sel)
				PID_SEL_MODE: begin
					next_st.prdata = {24'h000000, st.mode};
				end
				PID_SEL_POLARITY: begin
					next_st.prdata = {24'h000000, st.polarity};
				end
				PID_SEL_ENABLE: begin
					next_st.prdata = {24'h000000, st.enable};
				end
				PID_SEL_FLAGS: begin
					next_st.prdata = {24'h000000, st.flags};
				end
				PID_SEL_EXT_CTRL: begin
					next_st.prdata = {28'h0000000, st.ext_flag, st.trig_type};
				end
				default: begin
					next_st.prdata = 32'h00000000;
				end
			endcase
		end else if (access_done) begin
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.ext_sync1 <= `PID_RST_PIN_IDLE;
			st.ext_sync2 <= `PID_RST_PIN_IDLE;
			st.ext_prev <= `PID_RST_PIN_IDLE;
			st.ext_primed <= 1'b0;
			st.trig_type <= `PID_RST_TRIG;
			st.ext_flag <= 2'h0;
			st.mode <= `PID_RST_BYTE;
			st.polarity <= `PID_RST_BYTE;
			st.enable <= `PID_RST_BYTE;
			st.flags <= `PID_RST_BYTE;
			st.port_irq <= 1'b0;
			st.wake_req <= 1'b0;
			st.prdata <= 32'h00000000;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign ext_request_flag_zero = st.ext_flag[0];
	assign ext_request_flag_one = st.ext_flag[1];
	assign port_irq = st.port_irq;
	assign wake_req = st.wake_req;

endmodule // pid_top

// ==== pid_top_tb.sv ====
// Self-checking bench for the pin interrupt detector.
// Assumes the design, pid_src and pid_props are compiled first.
`timescale 1ns/1ps
`include "pid_consts.svh"
module pid_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, ext_request_pin_zero, ext_request_pin_one, port_irq, wake_req;
	logic svc_ack_zero = 1'b0, svc_ack_one = 1'b0, power_down = 1'b0;
	logic ext_request_flag_zero, ext_request_flag_one;
	logic [7:0] port1_pin_n;
	int n_mismatch = 0, check_count = 0;
	always #4 pclk = ~pclk;
	pid_top u_pid_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .ext_request_pin_zero, .ext_request_pin_one, .port1_pin_n, .svc_ack_zero, .svc_ack_one,
		.power_down, .ext_request_flag_zero, .ext_request_flag_one, .port_irq, .wake_req);
	pid_src u_pid_src (.pclk, .ext_pin_zero(ext_request_pin_zero), .ext_pin_one(ext_request_pin_one),
		.port_pins(port1_pin_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r,
		output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		chk(pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, i, 8'h00, r, e);
		chk(r, x);
		chk(e, xe);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			rd(8'(`PID_IDX_MODE + i), 32'h0, 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'(`PID_IDX_MODE + i), 8'h3c ^ i[7:0]);
			rd(8'(`PID_IDX_MODE + i), 32'h3c ^ i, 1'b0);
		end
		// A write without the low byte lane must leave the register as it was.
		pstrb <= 4'he;
		wr(`PID_IDX_MODE, 8'h55);
		pstrb <= 4'hf;
		rd(`PID_IDX_MODE, 32'h3c, 1'b0);
		// An unmapped word answers with an error and reads zero.
		rd(8'h00, 32'h0, 1'b1);
	endtask
	task automatic t_port_edge;
		wr(`PID_IDX_MODE, 8'hff);
		wr(`PID_IDX_POLARITY, 8'hff);
		wr(`PID_IDX_ENABLE, 8'h0f);
		wr(`PID_IDX_FLAGS, 8'h00);
		u_pid_src.drive(8'hff);
		repeat (20) @(posedge pclk);
		rd(`PID_IDX_FLAGS, 32'h0f, 1'b0);
		chk(port_irq, 1'b1);
		power_down <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(wake_req, 1'b1);
		power_down <= 1'b0;
		wr(`PID_IDX_FLAGS, 8'h00);
		wr(`PID_IDX_POLARITY, 8'h00);
		chk(port_irq, 1'b0);
		u_pid_src.drive(8'h00);
		repeat (6) @(posedge pclk);
		rd(`PID_IDX_FLAGS, 32'h0f, 1'b0);
		wr(`PID_IDX_FLAGS, 8'h00);
		rd(`PID_IDX_FLAGS, 32'h00, 1'b0);
	endtask
	task automatic t_port_level;
		wr(`PID_IDX_MODE, 8'h00);
		wr(`PID_IDX_POLARITY, 8'hf0);
		wr(`PID_IDX_ENABLE, 8'hff);
		wr(`PID_IDX_FLAGS, 8'h00);
		rd(`PID_IDX_FLAGS, 32'h0f, 1'b0);
		u_pid_src.drive(8'hb0);
		u_pid_src.drive(8'h30);
		repeat (8) @(posedge pclk);
		rd(`PID_IDX_FLAGS, 32'h3f, 1'b0);
		wr(`PID_IDX_ENABLE, 8'h00);
		wr(`PID_IDX_FLAGS, 8'h00);
		rd(`PID_IDX_FLAGS, 32'h00, 1'b0);
	endtask
	task automatic t_ext;
		wr(`PID_IDX_EXT_CTRL, 8'h01);
		u_pid_src.fall(1'b0);
		repeat (4) @(posedge pclk);
		chk(ext_request_flag_zero, 1'b1);
		@(posedge pclk) svc_ack_zero <= 1'b1;
		@(posedge pclk) svc_ack_zero <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(ext_request_flag_zero, 1'b0);
		u_pid_src.fall(1'b1);
		repeat (4) @(posedge pclk);
		chk(ext_request_flag_one, 1'b1);
		power_down <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(wake_req, 1'b1);
		u_pid_src.release_req();
		repeat (5) @(posedge pclk);
		chk(ext_request_flag_one, 1'b0);
		chk(wake_req, 1'b0);
		power_down <= 1'b0;
	endtask
	task automatic t_ext_one;
		u_pid_src.fall(1'b1);
		repeat (4) @(posedge pclk);
		chk(ext_request_flag_one, 1'b1);
		// Moving request one to edge mode drops its pending level request.
		wr(`PID_IDX_EXT_CTRL, 8'h03);
		rd(`PID_IDX_EXT_CTRL, 32'h03, 1'b0);
		u_pid_src.release_req();
		u_pid_src.fall(1'b1);
		repeat (4) @(posedge pclk);
		rd(`PID_IDX_EXT_CTRL, 32'h0b, 1'b0);
		@(posedge pclk) svc_ack_one <= 1'b1;
		@(posedge pclk) svc_ack_one <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(ext_request_flag_one, 1'b0);
		u_pid_src.release_req();
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_port_edge();
		t_port_level();
		t_ext();
		t_ext_one();
		finish_test();
	end
endmodule // pid_top_tb
bind pid_top pid_props u_pid_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
	.ext_request_pin_zero, .ext_request_pin_one, .power_down, .ext_request_flag_zero,
	.ext_request_flag_one, .port_irq, .wake_req);
